// *** logic/vwac_pkg.sv ***
package vwac_pkg;
	localparam logic [7:0] VWAC_OFS_ADDR_HIGH = 8'h3c;
	localparam logic [7:0] VWAC_OFS_PITCH     = 8'h3d;
	localparam logic [7:0] VWAC_OFS_CONTROL   = 8'h3e;
	localparam logic [7:0] VWAC_RST_REG       = 8'h00;
	localparam int VWAC_HIGH_PITCH_BIT = 5;
	localparam int VWAC_CTL_OCCLUDE    = 7;
	localparam int VWAC_CTL_DIFFUSE    = 5;
	localparam int VWAC_CTL_ZOOM_REP   = 4;
	localparam int VWAC_CTL_FMT_LSB    = 1;
	localparam int VWAC_CTL_ENABLE     = 0;
	localparam logic [7:0] VWAC_HIGH_RW_MASK = 8'h2f;
	localparam logic [7:0] VWAC_CTL_RW_MASK  = 8'hbf;
	localparam logic [11:0] VWAC_OVERRIDE_PITCH = 12'h400;
	localparam logic [2:0] VWAC_FMT_YUV422 = 3'h0;
	localparam logic [2:0] VWAC_FMT_PACKED = 3'h1;
	localparam logic [2:0] VWAC_FMT_LUT8   = 3'h2;
	localparam logic [2:0] VWAC_FMT_RGB555 = 3'h4;
	localparam logic [2:0] VWAC_FMT_RGB565 = 3'h5;
	typedef enum logic [1:0] {
		VWAC_DISP_OFF,
		VWAC_DISP_ARMED,
		VWAC_DISP_ON
	} vwac_disp_e;
endpackage

// *** logic/vwac_line_addr.sv ***
`timescale 1ns/10ps
// Scanline address counter: loads a base, then steps by a pitch.
module vwac_line_addr #(
	parameter int AW = 22
) (
	input  wire logic          mclk,
	input  wire logic          srst,
	input  wire logic          load,
	input  wire logic          step,
	input  wire logic [AW-1:0] base,
	input  wire logic [12:0]   pitch,
	output logic      [AW-1:0] addr
);
	wire logic [AW-1:0] stepped;

	// Wraps at the top of the address space, as the memory itself does.
	assign stepped = addr + AW'(pitch);

	// Load takes priority so a frame never starts from a stale line.
	always_ff @(posedge mclk) begin
		if (srst) begin
			addr <= '0;
		end else if (load) begin
			addr <= base;
		end else if (step) begin
			addr <= stepped;
		end
	end
endmodule

// *** logic/vwac_top.sv ***
`timescale 1ns/10ps
// Video window address and master control.
module vwac_top
	import vwac_pkg::*;
#(
	parameter int AW = 22
) (
	input  wire logic          mclk,
	input  wire logic          srst,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [7:0]    reg_index,
	input  wire logic [7:0]    reg_wdata,
	output logic      [7:0]    reg_rdata,
	input  wire logic [7:0]    buffer_address_low_reg,
	input  wire logic [7:0]    buffer_address_mid_reg,
	input  wire logic [1:0]    fine_byte_offset_reg,
	input  wire logic          capture_pitch_override_bit,
	input  wire logic          auto_decimation_enable_bit,
	input  wire logic          capture_interleave,
	input  wire logic          vsync,
	input  wire logic          window_first_line,
	input  wire logic          window_line_end,
	input  wire logic          capture_line_end,
	input  wire logic          capture_frame_start,
	input  wire logic [AW-1:0] capture_base,
	output logic      [AW-1:0] window_addr,
	output logic      [AW-1:0] capture_addr,
	output logic      [AW-1:0] start_addr,
	output logic      [11:0]   line_pitch,
	output logic               window_active,
	output logic               occlusion_en,
	output logic               diffusion_en,
	output logic               zoom_replicate,
	output logic      [2:0]    window_format,
	output logic               format_reserved,
	output logic               chroma_excess128,
	output logic               decimate_en
);
	// Register copies and the enable sequencer.
	logic [7:0]  buffer_address_high_reg;
	logic [7:0]  line_pitch_reg;
	logic [7:0]  window_master_control_reg;
	logic        vsync_q;
	vwac_disp_e  disp_state;
	vwac_disp_e  next_disp_state;

	// Decoded fields and assembled values, all combinational.
	wire logic        hit_high;
	wire logic        hit_pitch;
	wire logic        hit_ctl;
	wire logic        vsync_lead;
	wire logic        enable_bit;
	wire logic [2:0]  fmt;
	wire logic [11:0] pitch;
	wire logic [12:0] win_step;
	wire logic [12:0] cap_step;
	wire logic [AW-1:0] start;
	wire logic        fmt_rgb;
	wire logic        fmt_yuv;
	wire logic        fmt_packed;
	wire logic        fmt_lut8;
	wire logic        fmt_bad;
	wire logic        occlude_bit;
	wire logic        diffuse_bit;
	wire logic        zoom_rep_bit;
	wire logic        next_window_active;
	wire logic [7:0]  rd_mux;

	// Index decode for the three registers held here.
	assign hit_high  = reg_index == VWAC_OFS_ADDR_HIGH;
	assign hit_pitch = reg_index == VWAC_OFS_PITCH;
	assign hit_ctl   = reg_index == VWAC_OFS_CONTROL;
	assign vsync_lead = vsync & ~vsync_q;
	assign enable_bit = window_master_control_reg[VWAC_CTL_ENABLE];
	assign fmt = window_master_control_reg[VWAC_CTL_FMT_LSB +: 3];

	// Control fields picked out by name so the output stage stays short.
	assign occlude_bit  = window_master_control_reg[VWAC_CTL_OCCLUDE];
	assign diffuse_bit  = window_master_control_reg[VWAC_CTL_DIFFUSE];
	assign zoom_rep_bit = window_master_control_reg[VWAC_CTL_ZOOM_REP];

	// Address and pitch assembly from the register fields.
	// The pitch is a byte distance on an eight-byte grid, so its low three bits are tied off.
	assign start = {buffer_address_high_reg[3:0], buffer_address_mid_reg,
		buffer_address_low_reg, fine_byte_offset_reg};
	assign pitch = {buffer_address_high_reg[VWAC_HIGH_PITCH_BIT],
		line_pitch_reg, 3'h0};
	// Both counters step by the registered pitch unless the capture override is set, so a pitch write takes
	// effect on the same edge for fetch and capture; fetch steps by line_pitch, interleaved capture by twice it.
	assign win_step = {1'b0, line_pitch};
	// Override beats interleave: the fixed pitch is meant to be absolute.
	// Interleaved capture skips the other field's line, hence the doubled step.
	assign cap_step = capture_pitch_override_bit ? {1'b0, VWAC_OVERRIDE_PITCH}
		: (capture_interleave ? {line_pitch, 1'b0} : {1'b0, line_pitch});

	// Format decode; anything outside the five named codes is flagged, not remapped,
	// so downstream fetch logic can blank the window instead of guessing a format.
	assign fmt_yuv    = fmt == VWAC_FMT_YUV422;
	assign fmt_packed = fmt == VWAC_FMT_PACKED;
	assign fmt_lut8   = fmt == VWAC_FMT_LUT8;
	assign fmt_rgb    = (fmt == VWAC_FMT_RGB555) || (fmt == VWAC_FMT_RGB565);
	assign fmt_bad    = !(fmt_rgb || fmt_yuv || fmt_packed || fmt_lut8);

	// Read mux; reserved bits read as zero, unmapped indexes as zero.
	assign rd_mux = hit_high  ? (buffer_address_high_reg & VWAC_HIGH_RW_MASK) :
	                hit_pitch ? line_pitch_reg :
	                hit_ctl   ? (window_master_control_reg & VWAC_CTL_RW_MASK) : 8'h00;

	// Register writes; reserved bits are not stored.
	// Other indexes are ignored here; those registers belong to neighbouring blocks.
	always_ff @(posedge mclk) begin
		if (srst) begin
			buffer_address_high_reg   <= VWAC_RST_REG;
			line_pitch_reg            <= VWAC_RST_REG;
			window_master_control_reg <= VWAC_RST_REG;
		end else if (reg_wr) begin
			if (hit_high)
				buffer_address_high_reg <= reg_wdata & VWAC_HIGH_RW_MASK;
			if (hit_pitch)
				line_pitch_reg <= reg_wdata;
			if (hit_ctl)
				window_master_control_reg <= reg_wdata & VWAC_CTL_RW_MASK;
		end
	end

	// Enable sequencing: arm on a written one, go live on vsync rise.
	always_comb begin
		next_disp_state = disp_state;
		unique case (disp_state)
			VWAC_DISP_OFF: begin
				// A vsync rise in the cycle the enable lands already counts as the next one.
				if (enable_bit && vsync_lead)
					next_disp_state = VWAC_DISP_ON;
				else if (enable_bit)
					next_disp_state = VWAC_DISP_ARMED;
			end
			VWAC_DISP_ARMED: begin
				if (!enable_bit)
					next_disp_state = VWAC_DISP_OFF;
				else if (vsync_lead)
					next_disp_state = VWAC_DISP_ON;
			end
			VWAC_DISP_ON: begin
				if (!enable_bit)
					next_disp_state = VWAC_DISP_OFF;
			end
			// The spare fourth code of the state register falls back to off.
			default: next_disp_state = VWAC_DISP_OFF;
		endcase
	end

	// The window follows the next state, so a zero write drops it one edge later.
	assign next_window_active = (next_disp_state == VWAC_DISP_ON) && enable_bit;

	// State, edge detector and registered outputs.
	// The edge detector starts low, so vsync held high through reset shows one false rise;
	// that is harmless because the enable register is still clear at that edge.
	// Read data is captured on the strobe edge and then held until the next read.
	always_ff @(posedge mclk) begin
		if (srst) begin
			disp_state <= VWAC_DISP_OFF;
			vsync_q    <= 1'b0;
			reg_rdata  <= 8'h00;
		end else begin
			disp_state <= next_disp_state;
			vsync_q    <= vsync;
			if (reg_rd)
				reg_rdata <= rd_mux;
		end
	end

	// Mode outputs registered so every top output leaves a flip-flop.
	// The price is one edge of latency after each control write.
	// Occlusion is passed as written; keeping it off with interpolation is software's job.
	always_ff @(posedge mclk) begin
		if (srst) begin
			window_active    <= 1'b0;
			occlusion_en     <= 1'b0;
			diffusion_en     <= 1'b0;
			zoom_replicate   <= 1'b0;
			window_format    <= 3'h0;
			format_reserved  <= 1'b0;
			chroma_excess128 <= 1'b0;
			decimate_en      <= 1'b0;
			start_addr       <= '0;
			line_pitch       <= 12'h000;
		end else begin
			window_active    <= next_window_active;
			occlusion_en     <= occlude_bit;
			// Diffusion only means something while unpacking the compressed format.
			diffusion_en     <= diffuse_bit && fmt_packed;
			zoom_replicate   <= zoom_rep_bit;
			window_format    <= fmt;
			format_reserved  <= fmt_bad;
			chroma_excess128 <= fmt_yuv || fmt_packed;
			decimate_en      <= fmt_rgb && auto_decimation_enable_bit;
			start_addr       <= start;
			line_pitch       <= pitch;
		end
	end

	// Window fetch counter: start address on the frame's first line.
	// A load and a step in one cycle resolve in favour of the load inside the counter.
	vwac_line_addr #(.AW(AW)) u_win (
		.mclk  (mclk),
		.srst  (srst),
		.load  (window_first_line),
		.step  (window_line_end),
		.base  (start_addr),
		.pitch (win_step),
		.addr  (window_addr)
	);

	// Capture counter shares the pitch but has its own step rules.
	vwac_line_addr #(.AW(AW)) u_cap (
		.mclk  (mclk),
		.srst  (srst),
		.load  (capture_frame_start),
		.step  (capture_line_end),
		.base  (capture_base),
		.pitch (cap_step),
		.addr  (capture_addr)
	);
endmodule

// *** tb/vwac_checker.sv ***
`timescale 1ns/10ps
// Ties the address steps and the window enable to the inputs that cause them.
module vwac_checker (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_index,
	input wire logic [7:0]  reg_wdata,
	input wire logic        capture_pitch_override_bit,
	input wire logic        capture_interleave,
	input wire logic        vsync,
	input wire logic        window_first_line,
	input wire logic        window_line_end,
	input wire logic        capture_line_end,
	input wire logic        capture_frame_start,
	input wire logic [21:0] window_addr,
	input wire logic [21:0] capture_addr,
	input wire logic [21:0] start_addr,
	input wire logic [11:0] line_pitch,
	input wire logic        window_active,
	input wire logic [2:0]  window_format,
	input wire logic        format_reserved
);
	// One clock domain, so one clocking and one reset serve every check.
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	property p_pitch; line_pitch[2:0] == 3'h0; endproperty
	a_pitch: assert property (p_pitch) else $error("pitch low bits set");
	property p_load; window_first_line |=> window_addr == $past(start_addr); endproperty
	a_load: assert property (p_load) else $error("window load wrong");
	property p_step; window_line_end && !window_first_line
		|=> window_addr == $past(window_addr) + $past(line_pitch); endproperty
	a_step: assert property (p_step) else $error("window step wrong");
	property p_ovr; capture_line_end && !capture_frame_start && capture_pitch_override_bit
		|=> capture_addr == $past(capture_addr) + 12'h400; endproperty
	a_ovr: assert property (p_ovr) else $error("override step wrong");
	property p_cap; capture_line_end && !capture_frame_start && !capture_pitch_override_bit
		|=> capture_addr == $past(capture_addr)
		+ ($past({1'b0, line_pitch}) << $past(capture_interleave)); endproperty
	a_cap: assert property (p_cap) else $error("capture step wrong");
	property p_off; reg_wr && reg_index == 8'h3e && !reg_wdata[0] |-> ##[2:3] !window_active;
	endproperty
	a_off: assert property (p_off) else $error("window not stopped");
	property p_vs; !vsync ##1 !vsync |=> !$rose(window_active); endproperty
	a_vs: assert property (p_vs) else $error("window started without vsync");
	property p_rsv; format_reserved == (window_format == 3'h3 || window_format[2:1] == 2'h3);
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved format flag wrong");
endmodule
bind vwac_top vwac_checker u_chk (.*);

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	logic mclk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_q = 0, vsync = 0;
	logic capture_pitch_override_bit = 0, auto_decimation_enable_bit = 0, capture_interleave = 0;
	logic [7:0] reg_index = 0, reg_wdata = 0, buffer_address_low_reg = 0, buffer_address_mid_reg = 0;
	logic [7:0] reg_rdata, hi, pt, wd;
	logic [1:0] fine_byte_offset_reg = 0;
	logic [3:0] ev = 0;
	logic [21:0] capture_base = 0, window_addr, capture_addr, start_addr, exp, pw;
	logic [11:0] line_pitch;
	logic [2:0] window_format;
	logic window_active, occlusion_en, diffusion_en, zoom_replicate;
	logic format_reserved, chroma_excess128, decimate_en;
	logic [7:0] q[$];
	int n_fail = 0, comparisons = 0;
	vwac_top DUT (.*, .window_first_line(ev[3]), .window_line_end(ev[2]),
		.capture_frame_start(ev[1]), .capture_line_end(ev[0]));
	initial forever #5 mclk = ~mclk;
	task automatic chk(input logic [21:0] got, input logic [21:0] want);
		comparisons++;
		if (got !== want) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] want);
		comparisons++;
		if (got !== want) begin
			n_fail++;
			$display("CHECK FAILED %0t read %h want %h", $time, got, want);
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Strobes rise after one edge and fall after the next, so each is one cycle wide.
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1;
		reg_index <= i;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		q.push_back(e);
		@(posedge mclk);
		reg_rd <= 1;
		reg_index <= i;
		@(posedge mclk);
		reg_rd <= 0;
	endtask
	task automatic pulse(input logic [3:0] v);
		@(posedge mclk);
		ev <= v;
		@(posedge mclk);
		ev <= 0;
		#1;
	endtask
	// Read data lands one cycle after the strobe; compare it with the oldest note.
	always @(posedge mclk) begin
		if (rd_q)
			chk_rd(reg_rdata, q.pop_front());
		rd_q <= reg_rd;
	end
	// A hung run is cut short and counted as a mismatch.
	initial begin
		repeat (3000) @(posedge mclk);
		n_fail++;
		$display("CHECK FAILED %0t run timed out", $time);
		end_sim();
	end
	initial begin
		void'($urandom(30));
		hi = 8'($urandom);
		pt = 8'($urandom);
		repeat (4) @(posedge mclk);
		srst <= 0;
		{buffer_address_mid_reg, buffer_address_low_reg, fine_byte_offset_reg} <= 18'($urandom);
		capture_base <= 22'($urandom);
		rd(8'h3c, 0);
		rd(8'h3e, 0);
		wr(8'h40, 8'hff);
		rd(8'h40, 0);
		wr(8'h3c, hi);
		wr(8'h3d, pt);
		rd(8'h3c, hi & 8'h2f);
		rd(8'h3d, pt);
		exp = {hi[3:0], buffer_address_mid_reg, buffer_address_low_reg, fine_byte_offset_reg};
		pw = {hi[5], pt, 3'h0};
		pulse(4'h0);
		chk(line_pitch, pw);
		chk(start_addr, exp);
		pulse(4'hc);
		chk(window_addr, exp);
		pulse(4'h4);
		pulse(4'h4);
		chk(window_addr, exp + 2 * pw);
		pulse(4'h2);
		pulse(4'h1);
		chk(capture_addr, capture_base + pw);
		@(posedge mclk);
		capture_interleave <= 1;
		pulse(4'h1);
		chk(capture_addr, capture_base + 3 * pw);
		@(posedge mclk);
		capture_pitch_override_bit <= 1;
		pulse(4'h1);
		chk(capture_addr, capture_base + 3 * pw + 22'h400);
		for (int i = 0; i < 10; i++) begin
			// Occlusion only rides with replication; format 010 selects 8-bit LUT graphics.
			wd = {i[1] & i[0], 1'b1, ~i[3], i[0], i[2:0], 1'b0};
			@(posedge mclk);
			auto_decimation_enable_bit <= i[0];
			wr(8'h3e, wd);
			pulse(4'h0);
			chk({occlusion_en, diffusion_en, zoom_replicate, window_format, format_reserved,
				chroma_excess128, decimate_en}, {i[1] & i[0], i == 1, i[0], i[2:0],
				i[2:0] == 3 || i[2:0] > 5, i[2:0] < 2, i == 5});
			rd(8'h3e, wd & 8'hbf);
		end
		wr(8'h3e, 8'h01);
		rd(8'h3e, 8'h01);
		repeat (4) pulse(4'h0);
		chk(window_active, 0);
		@(posedge mclk);
		vsync <= 1;
		repeat (2) pulse(4'h0);
		chk(window_active, 1);
		wr(8'h3e, 8'h00);
		@(posedge mclk);
		#1;
		chk(window_active, 0);
		// Enabling while vsync is already high must wait for the following rise.
		wr(8'h3e, 8'h01);
		repeat (3) pulse(4'h0);
		chk(window_active, 0);
		@(posedge mclk);
		vsync <= 0;
		@(posedge mclk);
		vsync <= 1;
		repeat (2) pulse(4'h0);
		chk(window_active, 1);
		repeat (3) @(posedge mclk);
		if (q.size() != 0) begin
			n_fail++;
			$display("CHECK FAILED %0t unread notes %0d", $time, q.size());
		end
		end_sim();
	end
endmodule
